/* File: verilog/ubrg_regs.vh */
// Register offsets, field positions, reset values and timing figures of the
// baud-rate generator. Included by the generator top; no logic here.
`ifndef UBRG_REGS_VH
`define UBRG_REGS_VH

`define UBRG_ADDR_W        4
`define UBRG_OFF_PRESCALE  4'h0
`define UBRG_OFF_TX_DIV    4'h1
`define UBRG_OFF_RX_DIV    4'h2
`define UBRG_OFF_MODE      4'h3
`define UBRG_OFF_STATUS    4'h4

`define UBRG_PRS_LSB       0
`define UBRG_PRS_MSB       3
`define UBRG_DIV_LSB       9
`define UBRG_DIV_MSB       15

// 4800 bps from a 1 MHz operating clock: prescale 2^3 at 8 MHz system clock.
`define UBRG_PRESCALE_RST  16'h0003
`define UBRG_DIV_RST       16'hce00

// Connection methods.
`define UBRG_MODE_U2       3'h0
`define UBRG_MODE_U3       3'h1
`define UBRG_MODE_UDIV2    3'h2
`define UBRG_MODE_C4       3'h3
`define UBRG_MODE_C5       3'h4
`define UBRG_MODE_I3       3'h5

`define UBRG_MODE_RST      3'h0

`endif

/* File: verilog/ubrg_rate_counter.v */
// One bit-rate tick generator: counts operating clock enables.
// Assumes the enable is a one-cycle pulse on the system clock.
`timescale 1ns/100ps

module ubrg_rate_counter #(
  parameter DIV_W = 7
) (
  input  wire             clk_i,
  input  wire             reset_n_i,
  input  wire             mck_en_i,
  input  wire [DIV_W-1:0] divisor_i,
  output reg              tick_o
);

  // Half-bit period is divisor plus one enables, so a bit takes twice that.
  reg [DIV_W:0] cnt_q;
  wire [DIV_W:0] limit;

  assign limit = {1'b0, divisor_i};

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q  <= {(DIV_W+1){1'b0}};
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (mck_en_i)
      begin
        if (cnt_q >= limit)
        begin
          cnt_q  <= {(DIV_W+1){1'b0}};
          tick_o <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q + {{DIV_W{1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

/* File: verilog/ubrg_top.v */
// Baud-rate generator top: prescaler, transmit and receive rate ticks,
// wake-up use and stop permission. Assumes a single synchronous clock and a
// register port whose strobes are one cycle long and never overlap.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "ubrg_regs.vh"

// Functional notes
// - Operating clock is system clock over 2^prescale.
// - Divisor bits 15..9 give rate mck/(2(div+1)).
// - Separate transmit and receive divisors, shared prescaler.
// - Wake-up used in three-wire, branch, five-wire.
// - Reset defaults give 4800 bps both ways.
// - Stop allowed only two-wire async at 4800.
module ubrg_top #(
  parameter DIV_W = 7
) (
  input  wire                    clk_i,
  input  wire                    reset_n_i,
  input  wire [`UBRG_ADDR_W-1:0] addr_i,
  input  wire [15:0]             wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [15:0]             rdata_o,
  output wire                    mck_en_o,
  output wire                    tx_tick_o,
  output wire                    rx_tick_o,
  output reg                     wakeup_use_o,
  output reg                     stop_allow_o
);

  reg  [15:0] prescale_q;
  reg  [15:0] tx_div_q;
  reg  [15:0] rx_div_q;
  reg  [2:0]  mode_q;
  reg  [14:0] pre_cnt_q;
  reg         mck_en_q;
  wire [3:0]  prs;
  wire [14:0] pre_mask;
  wire        async_two_wire_select;
  wire [2*DIV_W-1:0] div_flat;
  wire [1:0]  tick;
  reg         wakeup_use_d;
  reg         stop_allow_d;

  assign prs = prescale_q[`UBRG_PRS_MSB:`UBRG_PRS_LSB];
  assign async_two_wire_select = (mode_q == `UBRG_MODE_U2);

  // Register writes; reset values give the 4800 bps default.
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      prescale_q <= `UBRG_PRESCALE_RST;
      tx_div_q   <= `UBRG_DIV_RST;
      rx_div_q   <= `UBRG_DIV_RST;
      mode_q     <= `UBRG_MODE_RST;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `UBRG_OFF_PRESCALE:
        begin
          prescale_q <= wdata_i;
        end
        `UBRG_OFF_TX_DIV:
        begin
          tx_div_q <= wdata_i;
        end
        `UBRG_OFF_RX_DIV:
        begin
          rx_div_q <= wdata_i;
        end
        `UBRG_OFF_MODE:
        begin
          mode_q <= wdata_i[2:0];
        end
        default:
        begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only.
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= 16'h0000;
    end
    else if (rd_i)
    begin
      case (addr_i)
        `UBRG_OFF_PRESCALE:
        begin
          rdata_o <= prescale_q;
        end
        `UBRG_OFF_TX_DIV:
        begin
          rdata_o <= tx_div_q;
        end
        `UBRG_OFF_RX_DIV:
        begin
          rdata_o <= rx_div_q;
        end
        `UBRG_OFF_MODE:
        begin
          rdata_o <= {13'h0000, mode_q};
        end
        `UBRG_OFF_STATUS:
        begin
          rdata_o <= {14'h0000, stop_allow_o, wakeup_use_o};
        end
        default:
        begin
          rdata_o <= 16'h0000;
        end
      endcase
    end
    else
    begin
      rdata_o <= 16'h0000;
    end
  end

  // A free-running counter gives an enable once every 2^prs cycles, which
  // avoids a derived clock and keeps the whole block on one clock tree.
  assign pre_mask = (15'h0001 << prs) - 15'h0001;

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      pre_cnt_q <= 15'h0000;
      mck_en_q  <= 1'b0;
    end
    else
    begin
      pre_cnt_q <= pre_cnt_q + 15'h0001;
      mck_en_q  <= ((pre_cnt_q & pre_mask) == pre_mask);
    end
  end

  assign mck_en_o = mck_en_q;

  // Channel 0 is transmit and channel 1 receive; both share one enable.
  assign div_flat = {rx_div_q[`UBRG_DIV_MSB:`UBRG_DIV_LSB],
                     tx_div_q[`UBRG_DIV_MSB:`UBRG_DIV_LSB]};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_rate
      ubrg_rate_counter #(
        .DIV_W (DIV_W)
      ) u_rate (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .mck_en_i  (mck_en_q),
        .divisor_i (div_flat[ch*DIV_W +: DIV_W]),
        .tick_o    (tick[ch])
      );
    end
  endgenerate

  assign tx_tick_o = tick[0];
  assign rx_tick_o = tick[1];

  // Wake-up use follows the connection method alone.
  always @*
  begin
    case (mode_q)
      `UBRG_MODE_U3:    wakeup_use_d = 1'b1;
      `UBRG_MODE_UDIV2: wakeup_use_d = 1'b1;
      `UBRG_MODE_C5:    wakeup_use_d = 1'b1;
      default:          wakeup_use_d = 1'b0;
    endcase
  end

  // Stop is allowed only while both directions still hold the default rate,
  // which is the only setting known to be 4800 bps at the 8 MHz system clock.
  always @*
  begin
    stop_allow_d = async_two_wire_select &&
                   (prescale_q == `UBRG_PRESCALE_RST) &&
                   (tx_div_q == `UBRG_DIV_RST) &&
                   (rx_div_q == `UBRG_DIV_RST);
  end

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      wakeup_use_o <= 1'b0;
      stop_allow_o <= 1'b0;
    end
    else
    begin
      wakeup_use_o <= wakeup_use_d;
      stop_allow_o <= stop_allow_d;
    end
  end

endmodule

/* File: sim/ubrg_properties.sv */
// Port checker for the baud-rate generator.
// Assumes a bind to ubrg_top; shadows writes to know the settings.
`timescale 1ns/100ps
module ubrg_properties (
  input wire        clk_i,
  input wire        reset_n_i,
  input wire [3:0]  addr_i,
  input wire [15:0] wdata_i,
  input wire        wr_i,
  input wire        mck_en_o,
  input wire        tx_tick_o,
  input wire        rx_tick_o,
  input wire        wakeup_use_o,
  input wire        stop_allow_o
);
  reg [3:0] p_q;
  reg [2:0] m_q;
  reg [6:0] t_q;
  reg [6:0] r_q;
  always @(posedge clk_i)
    if (!reset_n_i)
      {p_q, m_q, t_q, r_q} <= {4'h3, 3'h0, 7'h67, 7'h67};
    else if (wr_i && addr_i == 4'h0)
      p_q <= wdata_i[3:0];
    else if (wr_i && addr_i == 4'h1)
      t_q <= wdata_i[15:9];
    else if (wr_i && addr_i == 4'h2)
      r_q <= wdata_i[15:9];
    else if (wr_i && addr_i == 4'h3)
      m_q <= wdata_i[2:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  undiv_enable_a: assert property (
    p_q == 4'h0 |=> mck_en_o) else $error("enable missing");
  div_gap_a: assert property (
    mck_en_o && p_q != 4'h0 && $past(p_q) != 4'h0 |=> !mck_en_o)
    else $error("enable too close");
  tx_gap_a: assert property (
    tx_tick_o && t_q != 7'h0 |=> !tx_tick_o)
    else $error("tx tick too close");
  rx_gap_a: assert property (
    rx_tick_o && r_q != 7'h0 |=> !rx_tick_o)
    else $error("rx tick too close");
  wake_use_a: assert property (
    $past(reset_n_i, 2) |-> wakeup_use_o ==
    $past(m_q == 3'h1 || m_q == 3'h2 || m_q == 3'h4))
    else $error("wake");
  stop_perm_a: assert property (
    $past(reset_n_i, 2) |-> stop_allow_o ==
    $past(m_q == 3'h0 && p_q == 4'h3 && t_q == 7'h67 && r_q == 7'h67))
    else $error("stop");
endmodule

/* File: sim/ubrg_partner.sv */
// Far-end model: times the gap between bit-rate ticks.
// Assumes ticks are one-cycle pulses on the system clock.
`timescale 1ns/100ps
module ubrg_partner (
  input  wire        clk_i,
  input  wire        tick_i,
  output reg  [15:0] gap_o = 16'h0
);
  reg [15:0] cnt_q = 16'h0;
  always @(posedge clk_i)
    if (tick_i)
    begin
      gap_o <= cnt_q + 16'h1;
      cnt_q <= 16'h0;
    end
    else
      cnt_q <= cnt_q + 16'h1;
endmodule

/* File: sim/uart_baud_rate_generator_test.sv */
// Self-checking bench for the baud-rate generator.
// Assumes the design, checker and far-end model are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module uart_baud_rate_generator_test;
  reg clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0;
  reg [3:0] addr_i = 0, p;
  reg [15:0] wdata_i = 0, s = 16'h0015, v;
  reg [6:0] d, e;
  wire [15:0] rdata_o, tx_gap, rx_gap;
  wire mck_en_o, tx_tick_o, rx_tick_o, wakeup_use_o, stop_allow_o;
  int miscompares = 0, n_tests = 0;
  ubrg_top dut (.*);
  ubrg_partner tx_far (.clk_i(clk_i), .tick_i(tx_tick_o), .gap_o(tx_gap));
  ubrg_partner rx_far (.clk_i(clk_i), .tick_i(rx_tick_o), .gap_o(rx_gap));
  initial forever #5 clk_i = ~clk_i;
  function [15:0] per(input [3:0] q, input [6:0] n);
    per = (16'h1 << q) * (n + 16'h1);
  endfunction
  task wr(input [3:0] a, input [15:0] w);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task finish_test;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Worst case waits out a stale count of 9 enables per random setting.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    finish_test;
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(4'h1);
    `CHK(v, 16'hce00)
    rd(4'h2);
    `CHK(v, 16'hce00)
    rd(4'hf);
    `CHK(v, 16'h0)
    `CHK(stop_allow_o, 1'b1)
    for (int m = 5; m >= 0; m--)
    begin
      wr(4'h3, m[15:0]);
      repeat (2) @(posedge clk_i);
      #1 `CHK(wakeup_use_o, m == 1 || m == 2 || m == 4)
      `CHK(stop_allow_o, m == 0)
    end
    rd(4'h4);
    `CHK(v, 16'h0002)
    rd(4'h3);
    `CHK(v, 16'h0000)
    for (int i = 0; i < 6; i++)
    begin
      s = lfsr(s);
      p = s[1:0];
      d = s[4:2] + 7'h1;
      e = s[7:5] + 7'h1;
      wr(4'h0, {12'h0, p});
      wr(4'h1, {d, 9'h0});
      wr(4'h2, {e, 9'h0});
      repeat (1500) @(posedge clk_i);
      #1 `CHK(tx_gap, per(p, d))
      `CHK(rx_gap, per(p, e))
      `CHK(stop_allow_o, 1'b0)
      rd(4'h0);
      `CHK(v, {12'h0, p})
    end
    // A reset in mid-run must bring the 4800 bps defaults back.
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(4'h0);
    `CHK(v, 16'h0003)
    rd(4'h1);
    `CHK(v, 16'hce00)
    finish_test;
  end
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
endmodule
bind ubrg_top ubrg_properties chk (.*);
